// ---- hdl/ranging_mgmt_params.svh ----
// constants for the phy management controller: attribute ids, fields, reset values
`ifndef RANGING_MGMT_PARAMS_SVH
`define RANGING_MGMT_PARAMS_SVH

// attribute identifiers used by attribute_read and attribute_write
`define ATTR_ID_W 3
`define ATTR_MAX_PAYLOAD 3'h0
`define ATTR_POWER_LEVEL 3'h1
`define ATTR_CHAN_STATE 3'h2
`define ATTR_RANGE_CAPS 3'h3
`define ATTR_RANGE_ACC 3'h4
`define ATTR_RANGE_COUNT 3'h5

// fixed attribute values and reset values
`define MAX_PAYLOAD_OCTETS 32'h0000_0FFF
`define CAPS_DEFAULT 8'h71
`define ACCURACY_DEFAULT 8'h14
`define POWER_RESET_VAL 2'h1
`define CHAN_RESET_VAL 1'h0
`define COUNT_RESET_VAL 32'h0000_0000

// ranging capability bit positions
`define CAP_SUPPORTED 0
`define CAP_528 1
`define CAP_1056 2
`define CAP_2112 3
`define CAP_4224 4
`define CAP_MID 5
`define CAP_HIGH 6

// ranging count field bounds
`define BASE_HI 17
`define MID_LO 18
`define MID_HI 23
`define HIGH_LO 24
`define HIGH_HI 31

`endif

// ---- hdl/ranging_mgmt_pkg.sv ----
// types and shared decode functions for the phy management controller
package ranging_mgmt_pkg;
`include "ranging_mgmt_params.svh"

  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_READY = 2'b10
  } power_e;

  typedef enum logic {
    CHAN_CLEAR = 1'b0,
    CHAN_BUSY = 1'b1
  } chan_e;

  typedef enum logic {
    OUTCOME_SUCCESS = 1'b0,
    OUTCOME_FAILED = 1'b1
  } outcome_e;

  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_FLUSH = 2'b01,
    MG_DONE = 2'b10
  } mgmt_e;

  // lowest active count bit: finest clock present sets the resolution
  function automatic logic [1:0] ranging_lsb(input logic [7:0] caps);
    logic [1:0] l;
    l = 2'h3;
    if (caps[`CAP_4224]) begin
      l = 2'h0;
    end else if (caps[`CAP_2112]) begin
      l = 2'h1;
    end else if (caps[`CAP_1056]) begin
      l = 2'h2;
    end
    return l;
  endfunction

  // bits of the count that are allowed to be non-zero
  function automatic logic [31:0] ranging_mask(input logic [7:0] caps);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (caps[`CAP_SUPPORTED]) begin
      m[`BASE_HI:0] = 18'h3FFFF;
      if (caps[`CAP_MID]) begin
        m[`MID_HI:`MID_LO] = 6'h3F;
      end
      if (caps[`CAP_HIGH]) begin
        m[`HIGH_HI:`HIGH_LO] = 8'hFF;
      end
      m = m & ~((32'h0000_0001 << ranging_lsb(caps)) - 32'h0000_0001);
    end
    return m;
  endfunction

  // capability codes that the attribute may legally hold
  function automatic logic caps_valid(input logic [7:0] caps);
    logic v;
    case (caps)
      8'h00, 8'h03, 8'h05, 8'h09, 8'h11, 8'h23, 8'h25, 8'h29, 8'h31,
      8'h63, 8'h65, 8'h69, 8'h71: v = 1'b1;
      default: v = 1'b0;
    endcase
    return v;
  endfunction
endpackage

// ---- hdl/ranging_timer_core.sv ----
// ranging timer counter with capability-dependent active bits
`timescale 1ns/1ps
`include "ranging_mgmt_params.svh"
module ranging_timer_core import ranging_mgmt_pkg::*; #(
  parameter logic [7:0] CAPS = `CAPS_DEFAULT
) (
  // clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // timer control from the management entity
  input wire logic run,
  input wire logic clear,
  // masked count, registered
  output logic [31:0] count
);

  typedef struct packed {
    logic [31:0] count;
  } tmr_s;

  localparam logic [31:0] MASK = ranging_mask(CAPS);
  localparam logic [31:0] STEP = 32'h0000_0001 << ranging_lsb(CAPS);

  tmr_s st_ff;
  tmr_s nxt_st;

  // step the count; carries into inactive bits are masked, so it wraps
  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st.count = `COUNT_RESET_VAL;
    end else if (run) begin
      nxt_st.count = (st_ff.count + STEP) & MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.count;

  a_count_masked: assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.count & ~MASK) == 32'h0000_0000)
    else $error("ranging count has an inactive bit set");

  a_count_steps: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && run && !clear) |=> count == (($past(count) + STEP) & MASK))
    else $error("ranging count did not advance by one step");

endmodule

// ---- hdl/phy_management_cca_ranging_ctrl.sv ----
// phy management controller: assessment end, phy reset, ranging timer, attributes
//
// Summary of operation
// - end request halts assessment and state updates
// - confirm end once assessment stopped
// - max payload attribute reads 4095 octets
// - power level only sleep, standby or ready
// - activity state is busy or clear
// - capability bit 0 means ranging supported
// - capability bits 1-4 give timer clock
// - capability bits 5,6 enable upper count bits
// - accuracy attribute is 0 to 255 ppm
// - ranging count is 32-bit unsigned
// - low count bits zero below clock resolution
// - upper count bits zero when not enabled
// - capability holds only listed codes; an unlisted RANGING_CAPS is not refused, it makes the reset outcome failed
// - phy reset clears paths, assessment, attributes
// - reset confirm carries success or failed
// - timer start enables timer then confirms; a timer end in the same cycle wins, so the timer stays disabled while both confirm
// - enabled timer captured into count attribute
// - active assessment tracks channel result changes
// - timer end disables timer then confirms
`timescale 1ns/1ps
`include "ranging_mgmt_params.svh"
module phy_management_cca_ranging_ctrl import ranging_mgmt_pkg::*; #(
  parameter logic [7:0] RANGING_CAPS = `CAPS_DEFAULT,
  parameter logic [7:0] ACCURACY_PPM = `ACCURACY_DEFAULT
) (
  // clock, reset, clock enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // channel assessment result pin, asynchronous
  input wire logic channel_busy_pin,
  // assessment start and end handshakes
  input wire logic cca_start_req,
  output logic cca_start_cfm,
  input wire logic end_of_assessment_req,
  output logic end_of_assessment_cfm,
  // phy reset handshake
  input wire logic phy_reset_req,
  output logic phy_reset_cfm,
  output logic reset_outcome,
  output logic txrx_path_reset,
  // ranging timer handshakes
  input wire logic ranging_timer_start_req,
  output logic ranging_timer_start_cfm,
  input wire logic ranging_timer_end_req,
  output logic ranging_timer_end_cfm,
  // attribute read
  input wire logic attribute_read_req,
  input wire logic [`ATTR_ID_W-1:0] attribute_read_id,
  output logic attribute_read_cfm,
  output logic attribute_read_ok,
  output logic [31:0] attribute_read_data,
  // attribute write
  input wire logic attribute_write_req,
  input wire logic [`ATTR_ID_W-1:0] attribute_write_id,
  input wire logic [31:0] attribute_write_data,
  output logic attribute_write_cfm,
  output logic attribute_write_ok,
  // live state
  output logic cca_active,
  output logic ranging_timer_enabled,
  output logic channel_activity_state,
  output logic [1:0] phy_power_level
);

  typedef struct packed {
    mgmt_e mgmt;
    logic busy_meta;
    logic busy_sync;
    logic cca_active;
    chan_e chan;
    power_e power;
    logic timer_en;
    logic [31:0] count_value;
    logic cca_start_cfm;
    logic cca_end_cfm;
    logic rst_cfm;
    outcome_e outcome;
    logic path_reset;
    logic tstart_cfm;
    logic tend_cfm;
    logic rd_cfm;
    logic rd_ok;
    logic [31:0] rd_data;
    logic wr_cfm;
    logic wr_ok;
  } ctrl_s;

  ctrl_s st_ff;
  ctrl_s nxt_st;
  logic [31:0] timer_count;
  logic timer_clear;
  logic idle;

  // reset clears the timer in the flush step
  assign timer_clear = (st_ff.mgmt == MG_FLUSH);
  assign idle = (st_ff.mgmt == MG_IDLE);

  ranging_timer_core #(
    .CAPS(RANGING_CAPS)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .run(st_ff.timer_en),
    .clear(timer_clear),
    .count(timer_count)
  );

  // next state of the whole controller
  always_comb begin
    nxt_st = st_ff;
    // two-stage synchroniser for the result pin
    nxt_st.busy_meta = channel_busy_pin;
    nxt_st.busy_sync = st_ff.busy_meta;
    // confirms are one-cycle pulses
    nxt_st.cca_start_cfm = 1'b0;
    nxt_st.cca_end_cfm = 1'b0;
    nxt_st.rst_cfm = 1'b0;
    nxt_st.tstart_cfm = 1'b0;
    nxt_st.tend_cfm = 1'b0;
    nxt_st.rd_cfm = 1'b0;
    nxt_st.wr_cfm = 1'b0;

    if (st_ff.cca_active) begin
      nxt_st.chan = chan_e'(st_ff.busy_sync);
    end

    if (st_ff.timer_en) begin
      nxt_st.count_value = timer_count;
    end

    case (st_ff.mgmt)
      MG_IDLE: begin
        if (phy_reset_req) begin
          nxt_st.mgmt = MG_FLUSH;
          nxt_st.path_reset = 1'b1;
        end else begin
          if (cca_start_req) begin
            nxt_st.cca_active = 1'b1;
            nxt_st.cca_start_cfm = 1'b1;
          end
          if (end_of_assessment_req) begin
            nxt_st.cca_active = 1'b0;
            nxt_st.chan = st_ff.chan;
            nxt_st.cca_end_cfm = 1'b1;
          end
          if (ranging_timer_start_req) begin
            nxt_st.timer_en = 1'b1;
            nxt_st.tstart_cfm = 1'b1;
          end
          if (ranging_timer_end_req) begin
            nxt_st.timer_en = 1'b0;
            nxt_st.tend_cfm = 1'b1;
          end
          if (attribute_read_req) begin
            nxt_st.rd_cfm = 1'b1;
            nxt_st.rd_ok = 1'b1;
            nxt_st.rd_data = 32'h0000_0000;
            if (attribute_read_id == `ATTR_MAX_PAYLOAD) begin
              nxt_st.rd_data = `MAX_PAYLOAD_OCTETS;
            end else if (attribute_read_id == `ATTR_POWER_LEVEL) begin
              nxt_st.rd_data = {30'h0, st_ff.power};
            end else if (attribute_read_id == `ATTR_CHAN_STATE) begin
              nxt_st.rd_data = {31'h0, st_ff.chan};
            // clock and span bits as built
            end else if (attribute_read_id == `ATTR_RANGE_CAPS) begin
              nxt_st.rd_data = {24'h0, RANGING_CAPS};
            end else if (attribute_read_id == `ATTR_RANGE_ACC) begin
              nxt_st.rd_data = {24'h0, ACCURACY_PPM};
            end else if (attribute_read_id == `ATTR_RANGE_COUNT) begin
              nxt_st.rd_data = st_ff.count_value;
            end else begin
              nxt_st.rd_ok = 1'b0;
            end
          end
          if (attribute_write_req) begin
            nxt_st.wr_cfm = 1'b1;
            nxt_st.wr_ok = 1'b0;
            // only the three power levels accepted
            if (attribute_write_id == `ATTR_POWER_LEVEL &&
                attribute_write_data[31:2] == 30'h0 &&
                attribute_write_data[1:0] != 2'h3) begin
              nxt_st.power = power_e'(attribute_write_data[1:0]);
              nxt_st.wr_ok = 1'b1;
            end
          end
        end
      end
      MG_FLUSH: begin
        nxt_st.mgmt = MG_DONE;
        nxt_st.path_reset = 1'b0;
        nxt_st.cca_active = 1'b0;
        nxt_st.chan = chan_e'(`CHAN_RESET_VAL);
        nxt_st.power = power_e'(`POWER_RESET_VAL);
        nxt_st.timer_en = 1'b0;
        nxt_st.count_value = `COUNT_RESET_VAL;
        nxt_st.rd_ok = 1'b0;
        nxt_st.rd_data = 32'h0000_0000;
        nxt_st.wr_ok = 1'b0;
      end
      MG_DONE: begin
        nxt_st.mgmt = MG_IDLE;
        nxt_st.rst_cfm = 1'b1;
        nxt_st.outcome = caps_valid(RANGING_CAPS) ? OUTCOME_SUCCESS : OUTCOME_FAILED;
      end
      default: begin
        nxt_st.mgmt = MG_IDLE;
      end
    endcase
  end

  // single register stage, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.power <= power_e'(`POWER_RESET_VAL);
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign cca_start_cfm = st_ff.cca_start_cfm;
  assign end_of_assessment_cfm = st_ff.cca_end_cfm;
  assign phy_reset_cfm = st_ff.rst_cfm;
  assign reset_outcome = st_ff.outcome;
  assign txrx_path_reset = st_ff.path_reset;
  assign ranging_timer_start_cfm = st_ff.tstart_cfm;
  assign ranging_timer_end_cfm = st_ff.tend_cfm;
  assign attribute_read_cfm = st_ff.rd_cfm;
  assign attribute_read_ok = st_ff.rd_ok;
  assign attribute_read_data = st_ff.rd_data;
  assign attribute_write_cfm = st_ff.wr_cfm;
  assign attribute_write_ok = st_ff.wr_ok;
  assign cca_active = st_ff.cca_active;
  assign ranging_timer_enabled = st_ff.timer_en;
  assign channel_activity_state = st_ff.chan;
  assign phy_power_level = st_ff.power;

  // checks on the controller's visible behaviour
  // end confirmed with stop
  a_end_stops_cca: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && end_of_assessment_req)
      |=> end_of_assessment_cfm && !cca_active)
    else $error("assessment end not confirmed with assessment stopped");

  a_state_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    (!cca_active && idle && !cca_start_req && !phy_reset_req)
      |=> $stable(channel_activity_state))
    else $error("activity state changed while assessment stopped");

  a_state_tracks: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && cca_active && idle && !end_of_assessment_req && !phy_reset_req)
      |=> channel_activity_state == $past(st_ff.busy_sync))
    else $error("activity state did not follow assessed result");

  a_start_confirm: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && cca_start_req && !end_of_assessment_req)
      |=> cca_start_cfm && cca_active)
    else $error("assessment start not confirmed with assessment active");

  a_power_legal: assert property (@(posedge sys_clk) disable iff (rst)
    phy_power_level != 2'h3)
    else $error("power level holds an undefined code");

  a_write_refused: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && attribute_write_req &&
      (attribute_write_id != `ATTR_POWER_LEVEL || attribute_write_data > 32'h0000_0002))
      |=> attribute_write_cfm && !attribute_write_ok && $stable(phy_power_level))
    else $error("refused attribute write was accepted");

  a_reset_seq: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && phy_reset_req) ##1 clk_en ##1 clk_en
      |=> phy_reset_cfm && reset_outcome == !caps_valid(RANGING_CAPS))
    else $error("phy reset not confirmed two cycles after flush");

  a_path_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && phy_reset_req) |=> txrx_path_reset && !idle)
    else $error("phy reset did not pulse the tx/rx path reset");

  a_reset_clears: assert property (@(posedge sys_clk) disable iff (rst)
    phy_reset_cfm |-> !cca_active && !ranging_timer_enabled &&
      phy_power_level == `POWER_RESET_VAL && st_ff.count_value == 32'h0)
    else $error("attributes not at reset values after phy reset");

  a_busy_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !idle)
      |=> !cca_start_cfm && !end_of_assessment_cfm && !ranging_timer_start_cfm &&
        !ranging_timer_end_cfm && !attribute_read_cfm && !attribute_write_cfm)
    else $error("request answered during phy reset");

  a_timer_start: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && ranging_timer_start_req && !ranging_timer_end_req)
      |=> ranging_timer_start_cfm && ranging_timer_enabled)
    else $error("timer start not confirmed with timer enabled");

  a_timer_end: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && ranging_timer_end_req)
      |=> ranging_timer_end_cfm && !ranging_timer_enabled)
    else $error("timer end not confirmed with timer disabled");

  a_count_capture: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && ranging_timer_enabled && idle)
      |=> st_ff.count_value == $past(timer_count))
    else $error("count attribute did not capture the timer");

  a_count_read: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && attribute_read_req &&
      attribute_read_id == `ATTR_RANGE_COUNT)
      |=> (attribute_read_data & ~ranging_mask(RANGING_CAPS)) == 32'h0000_0000)
    else $error("count read shows a bit outside the active range");

  a_payload_read: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && idle && !phy_reset_req && attribute_read_req &&
      attribute_read_id == `ATTR_MAX_PAYLOAD)
      |=> attribute_read_cfm && attribute_read_data == 32'h0000_0FFF)
    else $error("payload limit read did not return 4095");

endmodule

// ---- verif/mac_mgmt_model.sv ----
// mac side model: issues management requests one at a time
`timescale 1ns/1ps
module mac_mgmt_model (
  // clock
  input wire logic sys_clk,
  // request pulses
  output logic cca_start_req,
  output logic end_of_assessment_req,
  output logic phy_reset_req,
  output logic ranging_timer_start_req,
  output logic ranging_timer_end_req,
  output logic attribute_read_req,
  output logic attribute_write_req,
  // request qualifiers
  output logic [2:0] attribute_read_id,
  output logic [2:0] attribute_write_id,
  output logic [31:0] attribute_write_data,
  // confirm pulses
  input wire logic cca_start_cfm,
  input wire logic end_of_assessment_cfm,
  input wire logic phy_reset_cfm,
  input wire logic ranging_timer_start_cfm,
  input wire logic ranging_timer_end_cfm,
  input wire logic attribute_read_cfm,
  input wire logic attribute_write_cfm
);
  logic [6:0] req = 7'h00;
  logic [6:0] cfm;

  // request and confirm lines by kind index
  assign {attribute_write_req, attribute_read_req, ranging_timer_end_req,
          ranging_timer_start_req, phy_reset_req, end_of_assessment_req,
          cca_start_req} = req;
  assign cfm = {attribute_write_cfm, attribute_read_cfm, ranging_timer_end_cfm,
                ranging_timer_start_cfm, phy_reset_cfm, end_of_assessment_cfm,
                cca_start_cfm};

  initial begin
    attribute_read_id = 3'h0;
    attribute_write_id = 3'h0;
    attribute_write_data = 32'h0000_0000;
  end

  // one outstanding request
  // pulse a request, then count cycles until its confirm, at most 8
  task automatic issue(input int k, input logic [2:0] id, input logic [31:0] d,
                       output int lat);
    @(negedge sys_clk);
    req[k] = 1'b1;
    attribute_read_id = id;
    attribute_write_id = id;
    attribute_write_data = d;
    @(negedge sys_clk);
    req[k] = 1'b0;
    // released qualifiers show garbage, not the last value
    attribute_read_id = ~id;
    attribute_write_id = ~id;
    attribute_write_data = ~d;
    lat = 1;
    while (cfm[k] !== 1'b1 && lat < 8) begin
      @(negedge sys_clk);
      lat++;
    end
  endtask
endmodule

// ---- verif/phy_management_cca_ranging_ctrl_test.sv ----
// self-checking bench for the phy management controller
`timescale 1ns/1ps
`include "ranging_mgmt_params.svh"
module phy_management_cca_ranging_ctrl_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic en = 1'b1;
  logic s_req, e_req, r_req, ts_req, te_req, rd_req, wr_req;
  logic s_cfm, e_cfm, r_cfm, ts_cfm, te_cfm, rd_cfm, wr_cfm;
  logic [2:0] rd_id, wr_id;
  logic [31:0] wr_data, rd_data, c0;
  logic rd_ok, wr_ok, outcome, path_rst, cca_on, tmr_on, chan;
  logic [1:0] pwr;
  int bad_count = 0;
  int check_count = 0;
  int path_cnt = 0;
  int lat;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // count cycles of the tx/rx path reset pulse
  always @(negedge sys_clk) if (path_rst === 1'b1) path_cnt++;

  phy_management_cca_ranging_ctrl #(.RANGING_CAPS(8'h23), .ACCURACY_PPM(8'hC8)) dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(en), .channel_busy_pin(pin),
    .cca_start_req(s_req), .cca_start_cfm(s_cfm),
    .end_of_assessment_req(e_req), .end_of_assessment_cfm(e_cfm),
    .phy_reset_req(r_req), .phy_reset_cfm(r_cfm), .reset_outcome(outcome),
    .txrx_path_reset(path_rst),
    .ranging_timer_start_req(ts_req), .ranging_timer_start_cfm(ts_cfm),
    .ranging_timer_end_req(te_req), .ranging_timer_end_cfm(te_cfm),
    .attribute_read_req(rd_req), .attribute_read_id(rd_id),
    .attribute_read_cfm(rd_cfm), .attribute_read_ok(rd_ok),
    .attribute_read_data(rd_data),
    .attribute_write_req(wr_req), .attribute_write_id(wr_id),
    .attribute_write_data(wr_data), .attribute_write_cfm(wr_cfm),
    .attribute_write_ok(wr_ok), .cca_active(cca_on), .ranging_timer_enabled(tmr_on),
    .channel_activity_state(chan), .phy_power_level(pwr));

  mac_mgmt_model mac (
    .sys_clk(sys_clk), .cca_start_req(s_req), .end_of_assessment_req(e_req),
    .phy_reset_req(r_req), .ranging_timer_start_req(ts_req),
    .ranging_timer_end_req(te_req), .attribute_read_req(rd_req),
    .attribute_write_req(wr_req), .attribute_read_id(rd_id),
    .attribute_write_id(wr_id), .attribute_write_data(wr_data),
    .cca_start_cfm(s_cfm), .end_of_assessment_cfm(e_cfm), .phy_reset_cfm(r_cfm),
    .ranging_timer_start_cfm(ts_cfm), .ranging_timer_end_cfm(te_cfm),
    .attribute_read_cfm(rd_cfm), .attribute_write_cfm(wr_cfm));

  // compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read an attribute and check the answer arrives next cycle
  task automatic rd(input logic [2:0] id);
    mac.issue(5, id, 32'h0000_0000, lat);
    chk(32'(lat), 32'h1);
    chk({31'h0, rd_ok}, (id <= 3'h5) ? 32'h1 : 32'h0);
  endtask

  // fixed attributes, reset power level, unknown id
  task automatic t_attrs();
    rd(3'h0);
    chk(rd_data, 32'h0000_0FFF);
    rd(3'h3);
    chk(rd_data, 32'h0000_0023);
    rd(3'h4);
    chk(rd_data, 32'h0000_00C8);
    rd(3'h1);
    chk(rd_data, 32'h0000_0001);
    rd(3'h6);
    chk({rd_ok, rd_data[30:0]}, 32'h0000_0000);
  endtask

  // power level writes: three legal values, one refused
  task automatic t_power();
    for (int v = 0; v < 4; v++) begin
      mac.issue(6, 3'h1, 32'(v), lat);
      chk({31'h0, wr_ok}, (v < 3) ? 32'h1 : 32'h0);
      rd(3'h1);
      chk(rd_data, (v < 3) ? 32'(v) : 32'h2);
    end
  endtask

  // assessment follows the pin until ended
  task automatic t_cca();
    mac.issue(0, 3'h0, 32'h0, lat);
    chk(32'(lat), 32'h1);
    chk({31'h0, cca_on}, 32'h1);
    pin = 1'b1;
    repeat (5) @(negedge sys_clk);
    rd(3'h2);
    chk(rd_data, 32'h1);
    pin = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({31'h0, chan}, 32'h0);
    mac.issue(1, 3'h0, 32'h0, lat);
    chk(32'(lat), 32'h1);
    chk({31'h0, cca_on}, 32'h0);
    pin = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({31'h0, chan}, 32'h0);
    pin = 1'b0;
  endtask

  // ranging timer start, capture, masking, end
  task automatic t_timer();
    mac.issue(3, 3'h0, 32'h0, lat);
    chk(32'(lat), 32'h1);
    chk({31'h0, tmr_on}, 32'h1);
    repeat (10) @(negedge sys_clk);
    rd(3'h5);
    c0 = rd_data;
    rd(3'h5);
    chk(rd_data - c0, 32'h10);
    chk({rd_data[31:24], 21'h0, rd_data[2:0]}, 32'h0);
    // clock enable low for five edges freezes timer and capture
    en = 1'b0;
    repeat (5) @(negedge sys_clk);
    en = 1'b1;
    c0 = rd_data;
    rd(3'h5);
    chk(rd_data - c0, 32'h10);
    mac.issue(4, 3'h0, 32'h0, lat);
    chk(32'(lat), 32'h1);
    chk({31'h0, tmr_on}, 32'h0);
    rd(3'h5);
    c0 = rd_data;
    repeat (4) @(negedge sys_clk);
    rd(3'h5);
    chk(rd_data, c0);
  endtask

  // phy reset clears state and confirms after three edges
  task automatic t_reset();
    mac.issue(6, 3'h1, 32'h2, lat);
    mac.issue(0, 3'h0, 32'h0, lat);
    mac.issue(3, 3'h0, 32'h0, lat);
    path_cnt = 0;
    mac.issue(2, 3'h0, 32'h0, lat);
    chk(32'(lat), 32'h3);
    chk({31'h0, outcome}, 32'h0);
    chk(32'(path_cnt), 32'h1);
    chk({28'h0, cca_on, tmr_on, pwr}, 32'h1);
    rd(3'h5);
    chk(rd_data, 32'h0);
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(50 * 4000);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_attrs();
    t_power();
    t_cca();
    t_timer();
    t_reset();
    finish_test();
  end
endmodule
